/* File: shared/galvo_vector_consts.svh */
/*
  Constants for the vector table ramp generator: command codes, ranges,
  reset values and timing counts.
  Assumes a 250 MHz clock and ASCII command bytes from the host link.
*/
`ifndef GALVO_VECTOR_CONSTS_SVH
`define GALVO_VECTOR_CONSTS_SVH

`define CLK_PERIOD_NS        4
`define MICROSECOND_NS       1000
`define US_CYCLES            (`MICROSECOND_NS / `CLK_PERIOD_NS)

`define ASCII_CR             8'h0d
`define ASCII_LF             8'h0a
`define ASCII_ZERO           8'h30
`define ASCII_NINE           8'h39

`define FIXED_COORDINATE_CMD 16'h4142
`define RELATIVE_MOVE_CMD    16'h444c
`define DRAW_X_CMD           16'h4e58
`define DRAW_Y_CMD           16'h4e59
`define SKIP_X_CMD           16'h4a58
`define SKIP_Y_CMD           16'h4a59
`define STEP_INTERVAL_CMD    16'h5350
`define DRAW_INCREMENT_CMD   16'h5353
`define SKIP_INCREMENT_CMD   16'h4a53

`define COORD_DEFAULT        17'h08000
`define PERIOD_MIN_US        16'h010e
`define PERIOD_MAX_US        16'hfffe
`define PERIOD_DEFAULT_3AX   16'h010e
`define PERIOD_DEFAULT_2AX   16'h00d2
`define STEP_SIZE_MAX        17'h07fff
`define DRAW_STEP_DEFAULT    15'h0020
`define SKIP_STEP_DEFAULT    15'h0200

`define TABLE_DEPTH          32000
`define TABLE_LIMIT          15'h7d00
`define FRAC_BITS            8

`define ERR_CHAR0            8'h49
`define ERR_CHAR1            8'h41
`define ERR_CHAR2            8'h0d

`endif

/* File: shared/galvo_vector_pkg.sv */
/*
  Types for the vector table ramp generator: table entry layout and states.
  Assumes nothing beyond the constants header.
*/
package galvo_vector_pkg;
  typedef struct packed {
    logic               laser;
    logic [15:0]        tgt_x;
    logic [15:0]        tgt_y;
    logic signed [24:0] inc_x;
    logic signed [24:0] inc_y;
    logic [16:0]        nsteps;
  } entry_type;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_SQRT = 3'h1, M_STEPS = 3'h3, M_INCX = 3'h2, M_INCY = 3'h6, M_WRITE = 3'h7
  } math_state_type;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0, E_READ = 2'h1, E_LOAD = 2'h3, E_STEP = 2'h2
  } exec_state_type;
endpackage

/* File: logic/vector_table_ram.sv */
/*
  Vector table memory: one write port, one read port with registered data.
  Assumes the caller keeps addresses below the table depth.
*/
`timescale 1ns/100ps
`include "galvo_vector_consts.svh"

module vector_table_ram (
  input  wire logic                       clk,
  input  wire logic                       wr_en,
  input  wire logic [14:0]                wr_addr,
  input  galvo_vector_pkg::entry_type     wr_data,
  input  wire logic [14:0]                rd_addr,
  output galvo_vector_pkg::entry_type     rd_data
);
  import galvo_vector_pkg::*;

  entry_type mem [0:`TABLE_DEPTH-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: logic/galvo_vector_table_ramp_generator.sv */
/*
  Vector table ramp generator: parses ASCII coordinate and speed commands,
  precomputes per-step increments into a table, and plays the table out as
  stepped ramps to the X and Y scanner DACs.
  Assumes bytes arrive already deserialised, synchronous to clk, and that a
  downstream transmitter accepts reply bytes with a valid/ready handshake.
*/
`timescale 1ns/100ps
`include "galvo_vector_consts.svh"

module galvo_vector_table_ramp_generator #(
  parameter bit TWO_AXIS = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic             invalid_arg,
  input  wire logic        exec_start,
  input  wire logic        clear_table,
  output logic             exec_busy,
  output logic [14:0]      table_count,
  output logic [15:0]      dac_x,
  output logic [15:0]      dac_y,
  output logic             laser_on
);
  import galvo_vector_pkg::*;

  logic [7:0]   c1_reg, c2_reg;
  logic [1:0]   nch_reg;
  logic [16:0]  acc_reg;
  logic         ovf_reg, have_arg_reg, junk_reg;
  logic         delta_reg, x_ok_reg;
  logic [15:0]  pend_x_reg, cur_x_reg, cur_y_reg, period_reg;
  logic [14:0]  draw_step_reg, skip_step_reg, step_m_reg;
  logic [1:0]   tx_idx_reg;
  logic         rx_ready_reg, tx_valid_reg, invalid_reg;
  logic [7:0]   tx_data_reg;
  math_state_type m_state;
  logic         laser_m_reg, sx_reg, sy_reg;
  logic [15:0]  tgt_x_m_reg, tgt_y_m_reg, dx_mag_reg, dy_mag_reg;
  logic [16:0]  root_reg, sbit_reg, n_reg;
  logic signed [24:0] incx_m_reg;
  logic [24:0]  div_rem_reg, div_quo_reg;
  logic [16:0]  div_den_reg;
  logic [4:0]   div_cnt_reg;
  logic [14:0]  count_reg, exec_idx_reg;
  exec_state_type e_state;
  entry_type    cur_entry_reg, rd_entry, wr_entry;
  logic [16:0]  nleft_reg;
  logic [7:0]   us_cnt_reg;
  logic [15:0]  sp_cnt_reg;
  logic [23:0]  pos_x_reg, pos_y_reg;
  logic         laser_reg, busy_reg;

  // Character path
  wire         rx_take   = rx_valid & rx_ready_reg;
  wire         is_cr     = rx_data == `ASCII_CR;
  wire         is_lf     = rx_data == `ASCII_LF;
  wire         is_digit  = (rx_data >= `ASCII_ZERO) & (rx_data <= `ASCII_NINE);
  wire [20:0]  acc_mul   = {1'b0, acc_reg, 3'h0} + {3'h0, acc_reg, 1'b0} + {17'h00000, rx_data[3:0]};
  wire [15:0]  cmd       = {c1_reg, c2_reg};
  wire         cmd_go    = rx_take & is_cr & (nch_reg == 2'h2);
  wire         is_fixed  = cmd == `FIXED_COORDINATE_CMD;
  wire         is_rel    = cmd == `RELATIVE_MOVE_CMD;
  wire         is_xcmd   = (cmd == `DRAW_X_CMD) | (cmd == `SKIP_X_CMD);
  wire         is_draw_y = cmd == `DRAW_Y_CMD;
  wire         is_ycmd   = is_draw_y | (cmd == `SKIP_Y_CMD);
  wire         is_period = cmd == `STEP_INTERVAL_CMD;
  wire         is_dinc   = cmd == `DRAW_INCREMENT_CMD;
  wire         is_sinc   = cmd == `SKIP_INCREMENT_CMD;

  // Argument checking
  wire [16:0]  arg_val   = have_arg_reg ? acc_reg : `COORD_DEFAULT;
  wire         arg_bad   = ovf_reg | junk_reg | arg_val[16];
  wire [15:0]  base      = is_xcmd ? cur_x_reg : cur_y_reg;
  wire [17:0]  delta_sum = {2'h0, base} + {{2{arg_val[15]}}, arg_val[15:0]};
  wire         coord_bad = arg_bad | (delta_reg & (delta_sum[17:16] != 2'h0));
  wire [15:0]  coord_val = delta_reg ? delta_sum[15:0] : arg_val[15:0];
  wire         period_bad = arg_bad | ~have_arg_reg | (arg_val[15:0] < `PERIOD_MIN_US) |
                            (arg_val[15:0] > `PERIOD_MAX_US);
  wire         size_bad  = arg_bad | ~have_arg_reg | (arg_val == 17'h00000) | (arg_val > `STEP_SIZE_MAX);
  wire         err_evt   = cmd_go & (((is_xcmd | is_ycmd) & coord_bad) | (is_period & period_bad) |
                                     ((is_dinc | is_sinc) & size_bad));
  wire         table_full = count_reg == `TABLE_LIMIT;
  wire         y_go      = cmd_go & is_ycmd & ~coord_bad & x_ok_reg & ~table_full;
  wire         exec_go   = exec_start & (e_state == E_IDLE) & (m_state == M_IDLE) & (count_reg != 15'h0000);

  // Pair geometry, taken from the current endpoint
  wire [16:0]  dx_w      = {1'b0, pend_x_reg} - {1'b0, cur_x_reg};
  wire [16:0]  dy_w      = {1'b0, coord_val} - {1'b0, cur_y_reg};
  wire [16:0]  dx_abs    = dx_w[16] ? (17'h00000 - dx_w) : dx_w;
  wire [16:0]  dy_abs    = dy_w[16] ? (17'h00000 - dy_w) : dy_w;

  // Length of the vector by bit-serial square root
  // Squares kept at full width; a product inside a concatenation would be cut to 16 bits
  wire [31:0]  sq_x      = dx_mag_reg * dx_mag_reg;
  wire [31:0]  sq_y      = dy_mag_reg * dy_mag_reg;
  wire [32:0]  sum_sq    = {1'b0, sq_x} + {1'b0, sq_y};
  wire [16:0]  trial     = root_reg | sbit_reg;
  wire [33:0]  trial_sq  = trial * trial;
  wire         keep_bit  = trial_sq <= {1'b0, sum_sq};

  // Shared restoring divider
  wire [24:0]  shift_rem = {div_rem_reg[23:0], div_quo_reg[24]};
  wire         div_ge    = shift_rem >= {8'h00, div_den_reg};
  wire         sqrt_done = (m_state == M_SQRT) & (sbit_reg == 17'h00000);
  wire         div_done  = div_cnt_reg == 5'h00;
  wire         div_load  = sqrt_done | (((m_state == M_STEPS) | (m_state == M_INCX)) & div_done);
  wire [16:0]  len_round = root_reg + {2'h0, step_m_reg} - 17'h00001;
  wire [16:0]  n_w       = (div_quo_reg[16:0] == 17'h00000) ? 17'h00001 : div_quo_reg[16:0];
  wire [24:0]  div_num_w = (m_state == M_SQRT) ? {8'h00, len_round} :
                           (m_state == M_STEPS) ? {1'b0, dx_mag_reg, 8'h00} : {1'b0, dy_mag_reg, 8'h00};
  wire [16:0]  div_den_w = (m_state == M_SQRT) ? {2'h0, step_m_reg} :
                           (m_state == M_STEPS) ? n_w : div_den_reg;
  wire signed [24:0] quo_signed = (m_state == M_INCX ? sx_reg : sy_reg) ?
                                  (25'h0000000 - div_quo_reg) : div_quo_reg;

  // Execution timing
  wire         us_tick   = us_cnt_reg == 8'(`US_CYCLES - 1);
  wire         step_due  = (e_state == E_STEP) & us_tick & (sp_cnt_reg + 16'h0001 >= period_reg);
  wire         last_step = nleft_reg == 17'h00001;
  wire         last_entry = exec_idx_reg + 15'h0001 == count_reg;
  wire [24:0]  next_x    = {1'b0, pos_x_reg} + cur_entry_reg.inc_x;
  wire [24:0]  next_y    = {1'b0, pos_y_reg} + cur_entry_reg.inc_y;
  wire [7:0]   msg_char  = (tx_idx_reg == 2'h1) ? `ERR_CHAR1 : `ERR_CHAR2;

  assign wr_entry = '{laser: laser_m_reg, tgt_x: tgt_x_m_reg, tgt_y: tgt_y_m_reg,
                      inc_x: incx_m_reg, inc_y: quo_signed, nsteps: n_reg};

  vector_table_ram table_mem (
    .clk     (clk),
    .wr_en   (m_state == M_INCY && div_done),
    .wr_addr (count_reg),
    .wr_data (wr_entry),
    .rd_addr (exec_idx_reg),
    .rd_data (rd_entry)
  );

  // Command line assembly; line feeds are taken and dropped
  always_ff @(posedge clk) begin
    if (rst || (rx_take && is_cr)) begin
      nch_reg      <= 2'h0;
      acc_reg      <= 17'h00000;
      ovf_reg      <= 1'b0;
      have_arg_reg <= 1'b0;
      junk_reg     <= 1'b0;
    end else if (rx_take && !is_lf) begin
      if (nch_reg != 2'h2) begin
        c1_reg  <= (nch_reg == 2'h0) ? rx_data : c1_reg;
        c2_reg  <= rx_data;
        nch_reg <= nch_reg + 2'h1;
      end else if (is_digit) begin
        acc_reg      <= acc_mul[16:0];
        ovf_reg      <= ovf_reg | (acc_mul[20:17] != 4'h0);
        have_arg_reg <= 1'b1;
      end else begin
        junk_reg <= 1'b1;
      end
    end
  end

  // Mode and speed settings
  always_ff @(posedge clk) begin
    if (rst) begin
      delta_reg     <= 1'b0;
      x_ok_reg      <= 1'b0;
      pend_x_reg    <= 16'(`COORD_DEFAULT);
      draw_step_reg <= `DRAW_STEP_DEFAULT;
      skip_step_reg <= `SKIP_STEP_DEFAULT;
      period_reg    <= TWO_AXIS ? `PERIOD_DEFAULT_2AX : `PERIOD_DEFAULT_3AX;
    end else if (cmd_go) begin
      // Mode applies alike under every drawing mode
      if (is_fixed || is_rel) begin
        delta_reg <= is_rel;
      end
      if (is_xcmd) begin
        x_ok_reg   <= !coord_bad;
        pend_x_reg <= coord_bad ? pend_x_reg : coord_val;
      end
      if (is_ycmd) begin
        x_ok_reg <= 1'b0;
      end
      if (is_period && !period_bad) begin
        period_reg <= arg_val[15:0];
      end
      if (is_dinc && !size_bad) begin
        draw_step_reg <= arg_val[14:0];
      end
      if (is_sinc && !size_bad) begin
        skip_step_reg <= arg_val[14:0];
      end
    end
  end

  // Error reply; a second error during a reply is not queued
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_idx_reg   <= 2'h0;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
      invalid_reg  <= 1'b0;
    end else begin
      invalid_reg <= err_evt;
      if (err_evt && !tx_valid_reg) begin
        tx_idx_reg   <= 2'h1;
        tx_valid_reg <= 1'b1;
        tx_data_reg  <= `ERR_CHAR0;
      end else if (tx_valid_reg && tx_ready) begin
        tx_idx_reg   <= (tx_idx_reg == 2'h3) ? 2'h0 : tx_idx_reg + 2'h1;
        tx_valid_reg <= tx_idx_reg != 2'h3;
        tx_data_reg  <= msg_char;
      end
    end
  end

  // Slope arithmetic as each pair completes
  always_ff @(posedge clk) begin
    if (rst) begin
      m_state   <= M_IDLE;
      cur_x_reg <= 16'(`COORD_DEFAULT);
      cur_y_reg <= 16'(`COORD_DEFAULT);
      count_reg <= 15'h0000;
    end else begin
      unique case (m_state)
        M_IDLE: begin
          if (clear_table && e_state == E_IDLE) begin
            count_reg <= 15'h0000;
          end
          if (y_go) begin
            m_state     <= M_SQRT;
            laser_m_reg <= is_draw_y;
            tgt_x_m_reg <= pend_x_reg;
            tgt_y_m_reg <= coord_val;
            sx_reg      <= dx_w[16];
            sy_reg      <= dy_w[16];
            dx_mag_reg  <= dx_abs[15:0];
            dy_mag_reg  <= dy_abs[15:0];
            step_m_reg  <= is_draw_y ? draw_step_reg : skip_step_reg;
            root_reg    <= 17'h00000;
            sbit_reg    <= 17'h10000;
          end
        end
        M_SQRT: begin
          root_reg <= keep_bit ? trial : root_reg;
          sbit_reg <= {1'b0, sbit_reg[16:1]};
          if (sqrt_done) begin
            m_state <= M_STEPS;
          end
        end
        M_STEPS: begin
          if (div_done) begin
            n_reg   <= n_w;
            m_state <= M_INCX;
          end
        end
        M_INCX: begin
          if (div_done) begin
            incx_m_reg <= quo_signed;
            m_state    <= M_INCY;
          end
        end
        M_INCY: begin
          if (div_done) begin
            count_reg <= count_reg + 15'h0001;
            cur_x_reg <= tgt_x_m_reg;
            cur_y_reg <= tgt_y_m_reg;
            m_state   <= M_WRITE;
          end
        end
        M_WRITE: begin
          m_state <= M_IDLE;
        end
        default: begin
          m_state <= M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_reg <= 5'h00;
      div_rem_reg <= 25'h0000000;
      div_quo_reg <= 25'h0000000;
      div_den_reg <= 17'h00001;
    end else if (div_load) begin
      div_cnt_reg <= 5'h19;
      div_rem_reg <= 25'h0000000;
      div_quo_reg <= div_num_w;
      div_den_reg <= div_den_w;
    end else if (!div_done) begin
      div_cnt_reg <= div_cnt_reg - 5'h01;
      div_rem_reg <= div_ge ? shift_rem - {8'h00, div_den_reg} : shift_rem;
      div_quo_reg <= {div_quo_reg[23:0], div_ge};
    end
  end

  // Playback of the table, one entry after another
  always_ff @(posedge clk) begin
    if (rst) begin
      e_state      <= E_IDLE;
      exec_idx_reg <= 15'h0000;
      pos_x_reg    <= {16'(`COORD_DEFAULT), 8'h00};
      pos_y_reg    <= {16'(`COORD_DEFAULT), 8'h00};
      laser_reg    <= 1'b0;
      nleft_reg    <= 17'h00000;
      us_cnt_reg   <= 8'h00;
      sp_cnt_reg   <= 16'h0000;
    end else begin
      us_cnt_reg <= (us_tick || e_state != E_STEP) ? 8'h00 : us_cnt_reg + 8'h01;
      if (e_state != E_STEP || step_due) begin
        sp_cnt_reg <= 16'h0000;
      end else if (us_tick) begin
        sp_cnt_reg <= sp_cnt_reg + 16'h0001;
      end
      unique case (e_state)
        E_IDLE: begin
          exec_idx_reg <= 15'h0000;
          e_state      <= exec_go ? E_READ : E_IDLE;
        end
        E_READ: begin
          e_state <= E_LOAD;
        end
        E_LOAD: begin
          cur_entry_reg <= rd_entry;
          nleft_reg     <= rd_entry.nsteps;
          laser_reg     <= rd_entry.laser;
          e_state       <= E_STEP;
        end
        E_STEP: begin
          if (step_due) begin
            nleft_reg <= nleft_reg - 17'h00001;
            if (last_step) begin
              pos_x_reg    <= {cur_entry_reg.tgt_x, 8'h00};
              pos_y_reg    <= {cur_entry_reg.tgt_y, 8'h00};
              exec_idx_reg <= exec_idx_reg + 15'h0001;
              laser_reg    <= last_entry ? 1'b0 : laser_reg;
              e_state      <= last_entry ? E_IDLE : E_READ;
            end else begin
              pos_x_reg <= next_x[23:0];
              pos_y_reg <= next_y[23:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_ready_reg <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      // Input is closed while arithmetic or playback runs
      rx_ready_reg <= (m_state == M_IDLE) && (e_state == E_IDLE) && !y_go && !exec_go;
      busy_reg     <= (e_state != E_IDLE && !(e_state == E_STEP && step_due && last_step && last_entry)) || exec_go;
    end
  end

  assign rx_ready    = rx_ready_reg;
  assign tx_data     = tx_data_reg;
  assign tx_valid    = tx_valid_reg;
  assign invalid_arg = invalid_reg;
  assign exec_busy   = busy_reg;
  assign table_count = count_reg;
  assign dac_x       = pos_x_reg[23:8];
  assign dac_y       = pos_y_reg[23:8];
  assign laser_on    = laser_reg;
endmodule

/* File: verification/galvo_vector_checker.sv */
/*
  Port checker for the vector table ramp generator, bound to its top module.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "galvo_vector_consts.svh"

module galvo_vector_checker #(
  parameter bit TWO_AXIS = 1'b0
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        rx_ready,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        invalid_arg,
  input wire logic        exec_start,
  input wire logic        exec_busy,
  input wire logic [14:0] table_count,
  input wire logic [15:0] dac_x,
  input wire logic [15:0] dac_y,
  input wire logic        laser_on
);
  // Shortest default hold; the counter loses one cycle at each move
  localparam int HOLD_MIN = (TWO_AXIS ? 210 : 270) * 250 - 1;
  logic [15:0] prev_x_reg;
  logic [15:0] prev_y_reg;
  logic [31:0] hold_reg;
  logic [31:0] hold_next;
  wire         dac_moved = (dac_x != prev_x_reg) || (dac_y != prev_y_reg);
  assign hold_next = (!exec_busy || dac_moved) ? 32'h0 : hold_reg + 32'h1;
  always_ff @(posedge clk) begin
    prev_x_reg <= dac_x;
    prev_y_reg <= dac_y;
    hold_reg   <= rst ? 32'h0 : hold_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_state_a: assert property (disable iff (1'b0) rst |=>
    !tx_valid && !invalid_arg && !exec_busy && !laser_on && table_count == 15'h0 && dac_x == 16'h8000
    && dac_y == 16'h8000) else $error("outputs not at reset state");
  reply_start_a: assert property (invalid_arg && !$past(tx_valid) |-> tx_valid && tx_data == `ERR_CHAR0)
    else $error("error reply did not start with the pulse");
  pulse_once_a: assert property (invalid_arg |=> !invalid_arg) else $error("error pulse too long");
  reply_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed before acceptance");
  count_step_a: assert property (table_count != $past(table_count) |->
    table_count == $past(table_count) + 15'h1 || table_count == 15'h0) else $error("table count jumped");
  exec_go_a: assert property (exec_start && !exec_busy && rx_ready && table_count != 15'h0 |=> exec_busy)
    else $error("playback did not start");
  dac_quiet_a: assert property (dac_moved && !$past(rst) |-> exec_busy || $past(exec_busy))
    else $error("dac moved outside playback");
  laser_play_a: assert property (laser_on |-> exec_busy || $past(exec_busy))
    else $error("laser on outside playback");
  step_hold_a: assert property (dac_moved && !$past(rst) |-> hold_reg >= HOLD_MIN)
    else $error("dac level held shorter than a step period");
endmodule

bind galvo_vector_table_ramp_generator galvo_vector_checker #(.TWO_AXIS(TWO_AXIS)) port_check (
  .clk(clk), .rst(rst), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .invalid_arg(invalid_arg), .exec_start(exec_start), .exec_busy(exec_busy), .table_count(table_count),
  .dac_x(dac_x), .dac_y(dac_y), .laser_on(laser_on));

/* File: verification/host_link_model.sv */
/*
  Host link model: offers ASCII command lines byte by byte, accepts replies.
  Assumes the bench calls send_line and sets slow; drives on the falling edge.
*/
`timescale 1ns/100ps

module host_link_model (
  input  wire logic clk,
  input  wire logic slow,
  output logic [7:0] rx_data,
  output logic       rx_valid,
  input  wire logic  rx_ready,
  output logic       tx_ready
);
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // A slow host takes a reply byte only every other cycle
  always @(negedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task automatic send_line(input string s);
    int i;
    for (i = 0; i < s.len(); i++) begin
      @(negedge clk);
      rx_data  = s[i];
      rx_valid = 1'b1;
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    // Released line shows the inverse so a stale byte never looks current
    rx_data  = ~rx_data;
  endtask
endmodule

/* File: verification/galvo_vector_table_ramp_generator_bench.sv */
/*
  Self-checking bench for the vector table ramp generator.
  Assumes the host link model drives the byte stream and the checker is bound.
*/
`timescale 1ns/100ps
`include "galvo_vector_consts.svh"

module galvo_vector_table_ramp_generator_bench;
  logic        clk;
  logic        rst;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic        invalid_arg;
  logic        exec_start;
  logic        clear_table;
  logic        exec_busy;
  logic [14:0] table_count;
  logic [15:0] dac_x;
  logic [15:0] dac_y;
  logic        laser_on;
  logic        slow;
  logic        laser_seen;
  logic [7:0]  reply_q[$];
  int          n_mismatch;
  int          n_tests;
  int          n_pulse;
  int          cycles;
  int          dx;
  int          dy;
  int          seed;

  // Two-axis default keeps the single playback step at 210 us
  galvo_vector_table_ramp_generator #(.TWO_AXIS(1'b1)) uut (
    .clk(clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .invalid_arg(invalid_arg), .exec_start(exec_start),
    .clear_table(clear_table), .exec_busy(exec_busy), .table_count(table_count), .dac_x(dac_x),
    .dac_y(dac_y), .laser_on(laser_on));
  host_link_model host (
    .clk(clk), .slow(slow), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_ready(tx_ready));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic expect_reply;
    reply_q.push_back(`ERR_CHAR0);
    reply_q.push_back(`ERR_CHAR1);
    reply_q.push_back(`ERR_CHAR2);
  endtask

  task automatic wait_count(input logic [14:0] n);
    int k;
    for (k = 0; k < 300 && table_count !== n; k++) @(negedge clk);
    check("table_count", {17'h0, n}, {17'h0, table_count});
    // Input stays closed two cycles after the count moves
    repeat (3) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (!rst && invalid_arg === 1'b1) begin
      n_pulse++;
    end
    if (!rst && laser_on === 1'b1) begin
      laser_seen = 1'b1;
    end
    if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (reply_q.size() == 0) begin
        check("unexpected reply", 32'h0, {24'h0, tx_data});
      end else begin
        check("reply byte", {24'h0, reply_q.pop_front()}, {24'h0, tx_data});
      end
    end
    // Ceiling: one playback step of 52500 cycles plus 37500 cycles for traffic
    if (cycles == 90000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    exec_start = 1'b0;
    clear_table = 1'b0;
    slow = 1'b0;
    laser_seen = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    n_pulse = 0;
    cycles = 0;
    seed = $urandom(20);
    dx = $urandom % 16;
    dy = $urandom % 16;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("dac_x", 32'h8000, {16'h0, dac_x});
    check("dac_y", 32'h8000, {16'h0, dac_y});
    // Short delta draw, well under one draw step, so playback is a single step
    host.send_line("DL\015");
    host.send_line($sformatf("NX%0d\015", dx));
    host.send_line($sformatf("\012NY%0d\015", dy));
    wait_count(15'h1);
    exec_start = 1'b1;
    @(negedge clk);
    exec_start = 1'b0;
    @(negedge clk);
    check("exec_busy", 32'h1, {31'h0, exec_busy});
    while (exec_busy === 1'b1 && cycles < 80000) @(negedge clk);
    check("dac_x end", 32'h8000 + dx, {16'h0, dac_x});
    check("dac_y end", 32'h8000 + dy, {16'h0, dac_y});
    check("laser during draw", 32'h1, {31'h0, laser_seen});
    check("laser after", 32'h0, {31'h0, laser_on});
    host.send_line("AB\015");
    host.send_line("JX65000\015");
    host.send_line("JY100\015");
    wait_count(15'h2);
    slow = 1'b1;
    host.send_line("DL\015");
    expect_reply();
    host.send_line("JX1000\015");
    host.send_line("JY0\015");
    host.send_line("NX65535\015");
    host.send_line("NY1\015");
    wait_count(15'h3);
    slow = 1'b0;
    host.send_line("NX0\015");
    expect_reply();
    host.send_line("NY65336\015");
    // Speed settings: out-of-range values answer with the error, legal ones do not
    expect_reply();
    host.send_line("SP269\015");
    host.send_line("SP270\015");
    host.send_line("SS100\015");
    expect_reply();
    host.send_line("JS0\015");
    // Longer than the arithmetic of one pair
    repeat (120) @(negedge clk);
    check("table_count", 32'h3, {17'h0, table_count});
    check("error pulses", 32'h4, n_pulse);
    check("replies left", 32'h0, reply_q.size());
    clear_table = 1'b1;
    @(negedge clk);
    clear_table = 1'b0;
    wait_count(15'h0);
    stop_test();
  end
endmodule
